// ===== design/mpc_top.sv
// Multifunction pin configuration with a Wishbone register port.
// Assumes a 20 MHz clk_i, synchronous rst_i and reference clocks of 13 and 26 MHz.
module mpc_top #(
    parameter int NET_HALF_CYCLES = mpc_pkg::NET_HALF_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [8:0] pin_i,
    output logic [8:0] pin_o,
    output logic [8:0] pin_oe_o,
    output logic [8:0] pin_pd_o,
    input wire logic mclk_ref13_i,
    input wire logic mclk_ref26_i,
    output logic master_clock_out_pin_o,
    input wire mpc_pkg::mpc_aud_tx_s aud_tx_i,
    output mpc_pkg::mpc_aud_rx_s aud_rx_o,
    input wire logic aud_active_i,
    input wire logic rtc_sync_i,
    input wire logic idle_i,
    output logic sim_enable_o,
    output logic wake_o,
    output logic irq_o
);
    localparam int QTR = (NET_HALF_CYCLES / 4 < 1) ? 1 : NET_HALF_CYCLES / 4;
    localparam int CW = (QTR < 2) ? 1 : $clog2(QTR);

    // ************************************************************************
    // State
    // ************************************************************************
    typedef struct packed {
        mpc_pkg::mpc_func_e [8:0] func;
        logic [8:0] out_lvl;
        mpc_pkg::mpc_net_e net;
        logic [4:0] ctrl;
        logic [3:0] irq_stat;
        logic [3:0] irq_mask;
        mpc_pkg::mpc_sim_e sim;
        logic sim_prev;
        logic rdy_prev;
        logic wake;
        logic gate;
        logic ack;
        logic [31:0] dat;
        logic [8:0] po;
        logic [8:0] poe;
        logic [8:0] ppd;
        mpc_pkg::mpc_aud_rx_s aud;
        logic [CW-1:0] cnt;
        logic [1:0] sub;
        logic fast;
        logic slow;
    } mpc_state_s;

    mpc_state_s s;
    mpc_state_s next_s;
    logic [8:0] pin_sync;

    // Pin levels cross into the clock domain here.
    mpc_sync #(
        .W(mpc_pkg::NUM_PINS)
    ) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i(pin_i),
        .q_o(pin_sync)
    );

    // Merges write data into an old word under the byte enables.
    function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] d, input logic [3:0] sel);
        logic [31:0] r;
        r = o;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) r[b*8 +: 8] = d[b*8 +: 8];
        end
        return r;
    endfunction

    // Builds the reset value of the whole state.
    function automatic mpc_state_s reset_state();
        mpc_state_s r;
        r = '0;
        for (int i = 0; i < mpc_pkg::NUM_PINS; i++) begin
            r.func[i] = mpc_pkg::default_func(i);
        end
        r.ctrl = mpc_pkg::CTRL_RESET;
        r.out_lvl = mpc_pkg::OUT_LEVEL_RESET;
        r.irq_stat = mpc_pkg::IRQ_RESET;
        r.irq_mask = mpc_pkg::IRQ_RESET;
        r.net = mpc_pkg::NET_NONE;
        r.sim = mpc_pkg::SIM_ON;
        return r;
    endfunction

    // ************************************************************************
    // Next state
    // ************************************************************************
    logic acc;
    logic wr;
    logic [3:0] idx;
    logic [31:0] rd;
    logic [31:0] wd;
    logic [8:0] in_lvl;
    logic net_lvl;
    logic rdy_on;
    logic rdy_rise;
    logic sim_on;
    logic sim_ins;
    logic sim_rem;
    logic [3:0] irq_set;
    logic [3:0] irq_clr;

    // Event detection on the synchronised pin levels.
    always_comb begin
        rdy_on = (s.func[mpc_pkg::GENERAL_PIN_THREE] == mpc_pkg::FN_RX_READY);
        rdy_rise = rdy_on & pin_sync[mpc_pkg::GENERAL_PIN_THREE] & ~s.rdy_prev;
        sim_on = (s.func[mpc_pkg::GENERAL_PIN_FIVE] == mpc_pkg::FN_SIM_DETECT)
            | (s.func[mpc_pkg::GENERAL_PIN_FIVE] == mpc_pkg::FN_SIM_HOT);
        sim_ins = sim_on & pin_sync[mpc_pkg::GENERAL_PIN_FIVE] & ~s.sim_prev;
        sim_rem = sim_on & ~pin_sync[mpc_pkg::GENERAL_PIN_FIVE] & s.sim_prev;
        for (int i = 0; i < mpc_pkg::NUM_PINS; i++) begin
            in_lvl[i] = (s.func[i] == mpc_pkg::FN_INPUT) & pin_sync[i];
        end
    end

    // Network status level from the blink phases.
    always_comb begin
        case (s.net)
            mpc_pkg::NET_NONE: net_lvl = 1'b0;
            mpc_pkg::NET_HOME: net_lvl = s.slow;
            mpc_pkg::NET_ROAM: net_lvl = s.fast;
            default: net_lvl = 1'b1;
        endcase
    end

    // Register access, pin drive and event handling.
    always_comb begin
        next_s = s;
        acc = wb_cyc_i & wb_stb_i & ~s.ack;
        wr = acc & wb_we_i;
        idx = wb_adr_i[5:2];
        next_s.ack = acc;
        rd = 32'h0000_0000;
        wd = 32'h0000_0000;
        irq_clr = 4'h0;
        // Read and write decode; unmapped addresses read zero and ignore writes.
        if (wb_adr_i < mpc_pkg::ADDR_OUT_LEVEL) begin
            rd = {28'h000_0000, s.func[idx]};
            wd = wmerge(rd, wb_dat_i, wb_sel_i);
            if (wr && mpc_pkg::func_allowed(int'(idx), wd[3:0])) begin
                next_s.func[idx] = mpc_pkg::mpc_func_e'(wd[3:0]);
            end
        end else if (wb_adr_i == mpc_pkg::ADDR_OUT_LEVEL) begin
            rd = {23'h00_0000, s.out_lvl};
            wd = wmerge(rd, wb_dat_i, wb_sel_i);
            if (wr) next_s.out_lvl = wd[8:0];
        end else if (wb_adr_i == mpc_pkg::ADDR_IN_LEVEL) begin
            rd = {23'h00_0000, in_lvl};
        end else if (wb_adr_i == mpc_pkg::ADDR_NET) begin
            rd = {30'h0000_0000, s.net};
            wd = wmerge(rd, wb_dat_i, wb_sel_i);
            if (wr) next_s.net = mpc_pkg::mpc_net_e'(wd[1:0]);
        end else if (wb_adr_i == mpc_pkg::ADDR_CTRL) begin
            rd = {27'h000_0000, s.ctrl};
            wd = wmerge(rd, wb_dat_i, wb_sel_i);
            if (wr) next_s.ctrl = wd[4:0];
        end else if (wb_adr_i == mpc_pkg::ADDR_IRQ_STAT) begin
            rd = {28'h000_0000, s.irq_stat};
            wd = wmerge(32'h0000_0000, wb_dat_i, wb_sel_i);
            if (wr) irq_clr = wd[3:0];
        end else if (wb_adr_i == mpc_pkg::ADDR_IRQ_MASK) begin
            rd = {28'h000_0000, s.irq_mask};
            wd = wmerge(rd, wb_dat_i, wb_sel_i);
            if (wr) next_s.irq_mask = wd[3:0];
        end else if (wb_adr_i == mpc_pkg::ADDR_SIM) begin
            rd = {30'h0000_0000, s.sim, s.sim_prev & sim_on};
        end
        if (acc) next_s.dat = rd;
        // Sticky events; a new event wins over a clear in the same cycle.
        irq_set = 4'h0;
        irq_set[mpc_pkg::IRQ_READY] = rdy_rise;
        irq_set[mpc_pkg::IRQ_SIM_IN] = sim_ins;
        irq_set[mpc_pkg::IRQ_SIM_OUT] = sim_rem;
        next_s.wake = s.ctrl[mpc_pkg::CTRL_PWR_SAVE] & idle_i & rdy_on
            & pin_sync[mpc_pkg::GENERAL_PIN_THREE];
        irq_set[mpc_pkg::IRQ_WAKE] = next_s.wake & ~s.wake;
        next_s.irq_stat = (s.irq_stat & ~irq_clr) | irq_set;
        next_s.rdy_prev = pin_sync[mpc_pkg::GENERAL_PIN_THREE];
        next_s.sim_prev = pin_sync[mpc_pkg::GENERAL_PIN_FIVE];
        // SIM interface follows insertion and removal in hot mode only.
        if (s.func[mpc_pkg::GENERAL_PIN_FIVE] == mpc_pkg::FN_SIM_HOT) begin
            case (s.sim)
                mpc_pkg::SIM_OFF: if (sim_ins) next_s.sim = mpc_pkg::SIM_ON;
                default: if (sim_rem) next_s.sim = mpc_pkg::SIM_OFF;
            endcase
        end
        // Master clock gate: continuous, or only while audio runs.
        next_s.gate = s.ctrl[mpc_pkg::CTRL_MCLK_EN]
            & (s.ctrl[mpc_pkg::CTRL_MCLK_CONT] | aud_active_i);
        // Blink phases for the network status pin.
        if (s.cnt == CW'(QTR - 1)) begin
            next_s.cnt = '0;
            next_s.fast = ~s.fast;
            next_s.sub = s.sub + 2'h1;
            if (s.sub == 2'h3) next_s.slow = ~s.slow;
        end else begin
            next_s.cnt = s.cnt + CW'(1);
        end
        // Per-pin drive and sense; only the selected function reaches a pin.
        for (int i = 0; i < mpc_pkg::NUM_PINS; i++) begin
            next_s.po[i] = 1'b0;
            next_s.poe[i] = 1'b0;
            next_s.ppd[i] = 1'b0;
            case (s.func[i])
                mpc_pkg::FN_DISABLED: next_s.ppd[i] = 1'b1;
                mpc_pkg::FN_OUTPUT: begin
                    next_s.poe[i] = 1'b1;
                    next_s.po[i] = s.out_lvl[i];
                end
                mpc_pkg::FN_NET_STATUS: begin
                    next_s.poe[i] = 1'b1;
                    next_s.po[i] = net_lvl;
                end
                mpc_pkg::FN_RX_SUPPLY: begin
                    next_s.poe[i] = 1'b1;
                    next_s.po[i] = s.ctrl[mpc_pkg::CTRL_RX_SUPPLY];
                end
                mpc_pkg::FN_RTC_SHARE: begin
                    next_s.poe[i] = 1'b1;
                    next_s.po[i] = rtc_sync_i;
                end
                mpc_pkg::FN_AUDIO: begin
                    if (i == mpc_pkg::AUDIO_TXD_PIN) begin
                        next_s.poe[i] = 1'b1;
                        next_s.po[i] = aud_tx_i.tx_data;
                    end else if (i == mpc_pkg::AUDIO_CLK_PIN) begin
                        next_s.poe[i] = aud_tx_i.clk_oe;
                        next_s.po[i] = aud_tx_i.clk_out;
                    end else if (i == mpc_pkg::AUDIO_WORD_ALIGN_PIN) begin
                        next_s.poe[i] = aud_tx_i.wa_oe;
                        next_s.po[i] = aud_tx_i.wa_out;
                    end
                end
                default: next_s.poe[i] = 1'b0;
            endcase
        end
        // Audio inputs read zero unless their pin holds the audio function.
        next_s.aud.rx_data = (s.func[mpc_pkg::AUDIO_RXD_PIN] == mpc_pkg::FN_AUDIO)
            & pin_sync[mpc_pkg::AUDIO_RXD_PIN];
        next_s.aud.clk_in = (s.func[mpc_pkg::AUDIO_CLK_PIN] == mpc_pkg::FN_AUDIO)
            & pin_sync[mpc_pkg::AUDIO_CLK_PIN];
        next_s.aud.wa_in = (s.func[mpc_pkg::AUDIO_WORD_ALIGN_PIN] == mpc_pkg::FN_AUDIO)
            & pin_sync[mpc_pkg::AUDIO_WORD_ALIGN_PIN];
    end

    // The whole state registers here.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s <= reset_state();
        end else begin
            s <= next_s;
        end
    end

    // ************************************************************************
    // Outputs
    // ************************************************************************
    // Register-driven outputs; the interrupt is the masked status.
    assign wb_dat_o = s.dat;
    assign wb_ack_o = s.ack;
    assign pin_o = s.po;
    assign pin_oe_o = s.poe;
    assign pin_pd_o = s.ppd;
    assign aud_rx_o = s.aud;
    assign sim_enable_o = (s.sim == mpc_pkg::SIM_ON);
    assign wake_o = s.wake;
    assign irq_o = |(s.irq_stat & s.irq_mask);

    // The reference clocks are gated by a flop of this domain; a gate change
    // may shorten one reference half period at the pin.
    assign master_clock_out_pin_o = s.gate
        & (s.ctrl[mpc_pkg::CTRL_MCLK_26] ? mclk_ref26_i : mclk_ref13_i);

    // ************************************************************************
    // Assertions
    // ************************************************************************
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence sim_ins_seq;
        (s.func[mpc_pkg::GENERAL_PIN_FIVE] == mpc_pkg::FN_SIM_HOT) && sim_ins;
    endsequence

    sequence sim_rem_seq;
        (s.func[mpc_pkg::GENERAL_PIN_FIVE] == mpc_pkg::FN_SIM_HOT) && sim_rem;
    endsequence

    a_mclk_cont_on: assert property (
        (s.ctrl[mpc_pkg::CTRL_MCLK_EN] && s.ctrl[mpc_pkg::CTRL_MCLK_CONT]) |=> s.gate)
        else $error("Continuous master clock is not running.");

    a_mclk_aud_off: assert property (
        (!s.ctrl[mpc_pkg::CTRL_MCLK_CONT] && !aud_active_i) |=> !master_clock_out_pin_o)
        else $error("Master clock runs without audio activity.");

    a_sim_hot_ins: assert property (sim_ins_seq |=> sim_enable_o)
        else $error("SIM interface not enabled after insertion.");

    a_sim_hot_rem: assert property (sim_rem_seq |=> !sim_enable_o ##1 (!sim_enable_o || $past(sim_ins)))
        else $error("SIM interface not disabled after removal.");

    a_wake_ready: assert property (
        (s.ctrl[mpc_pkg::CTRL_PWR_SAVE] && idle_i && rdy_on && pin_sync[mpc_pkg::GENERAL_PIN_THREE])
        |=> wake_o)
        else $error("Data-ready did not wake the module.");

    a_ready_sticky: assert property (rdy_rise |=> s.irq_stat[mpc_pkg::IRQ_READY])
        else $error("Data-ready event lost.");

    a_net_data_high: assert property (
        (s.func[0] == mpc_pkg::FN_NET_STATUS && s.net == mpc_pkg::NET_DATA) |=> (pin_o[0] && pin_oe_o[0]))
        else $error("Data state not shown on pin one.");

    a_wb_ack_once: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
        else $error("Bus answer is not a single cycle.");

    for (genvar g = 0; g < mpc_pkg::NUM_PINS; g++) begin : g_pin_chk
        // The sampled reset keeps the releasing edge out, where pins still hold reset drive.
        a_dis_pulldown: assert property (
            (!rst_i && s.func[g] == mpc_pkg::FN_DISABLED) |=> (pin_pd_o[g] && !pin_oe_o[g]))
            else $error("Disabled pin not floating with pull-down.");
        a_out_level: assert property (
            (!rst_i && s.func[g] == mpc_pkg::FN_OUTPUT) |=> (pin_oe_o[g] && pin_o[g] == $past(s.out_lvl[g])))
            else $error("Output pin does not follow its level.");
        a_legal_func: assert property (mpc_pkg::func_allowed(g, s.func[g]))
            else $error("Pin holds a function it cannot carry.");
    end
endmodule

// ===== design/mpc_pkg.sv
// Constants, types and helpers for the multifunction pin configuration block.
// Assumes a 20 MHz system clock, a synchronous reset and a classic Wishbone master.
// ****************************************************************************
// Summary of operation
// - The master clock pin outputs a square wave of 13 MHz or 26 MHz chosen by software.
// - The master clock runs only while audio is active in audio mode, or always in continuous mode.
// - Nine pins each hold one selectable function: general input, general output or a custom function.
// - Network status can go on any of the first four pins, has no default and shows four states.
// - The receiver supply enable defaults to pin two, may move to pins one to four and switches the supply.
// - The receiver data-ready input is sensed only on pin three, which is its default.
// - The RTC sync output exists only on pin four and is off after reset.
// - SIM presence detection is an input on pin five only, which defaults to it.
// - In hot insertion mode the SIM interface is enabled on insertion and disabled on removal.
// - A pin set as general input lets software read its high or low level.
// - A pin set as general output drives a software level, and pin four defaults to it.
// - A disabled pin floats with its pull-down on, and pin one is disabled after reset.
// - The four audio pins default to the audio function and may become input, output or disabled.
// - With power saving on and the module idle, data-ready high raises the wake output.
// ****************************************************************************
package mpc_pkg;
    localparam int NUM_PINS = 9;
    localparam int ADR_W = 8;
    // Pin positions in the pin vectors.
    localparam int GENERAL_PIN_ONE = 0;
    localparam int GENERAL_PIN_TWO = 1;
    localparam int GENERAL_PIN_THREE = 2;
    localparam int GENERAL_PIN_FOUR = 3;
    localparam int GENERAL_PIN_FIVE = 4;
    localparam int AUDIO_TXD_PIN = 5;
    localparam int AUDIO_RXD_PIN = 6;
    localparam int AUDIO_CLK_PIN = 7;
    localparam int AUDIO_WORD_ALIGN_PIN = 8;
    // Function codes held per pin.
    typedef enum logic [3:0] {
        FN_DISABLED = 4'h0,
        FN_INPUT = 4'h1,
        FN_OUTPUT = 4'h2,
        FN_NET_STATUS = 4'h3,
        FN_RX_SUPPLY = 4'h4,
        FN_RX_READY = 4'h5,
        FN_RTC_SHARE = 4'h6,
        FN_SIM_DETECT = 4'h7,
        FN_SIM_HOT = 4'h8,
        FN_AUDIO = 4'h9
    } mpc_func_e;
    typedef enum logic [1:0] {
        NET_NONE = 2'h0,
        NET_HOME = 2'h1,
        NET_ROAM = 2'h2,
        NET_DATA = 2'h3
    } mpc_net_e;
    typedef enum logic {
        SIM_OFF = 1'h0,
        SIM_ON = 1'h1
    } mpc_sim_e;
    // Register byte addresses.
    localparam logic [7:0] ADDR_FUNC_BASE = 8'h00;
    localparam logic [7:0] ADDR_OUT_LEVEL = 8'h24;
    localparam logic [7:0] ADDR_IN_LEVEL = 8'h28;
    localparam logic [7:0] ADDR_NET = 8'h2C;
    localparam logic [7:0] ADDR_CTRL = 8'h30;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h34;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h38;
    localparam logic [7:0] ADDR_SIM = 8'h3C;
    // Control register fields.
    localparam int CTRL_W = 5;
    localparam int CTRL_RX_SUPPLY = 0;
    localparam int CTRL_MCLK_EN = 1;
    localparam int CTRL_MCLK_26 = 2;
    localparam int CTRL_MCLK_CONT = 3;
    localparam int CTRL_PWR_SAVE = 4;
    localparam logic [4:0] CTRL_RESET = 5'h00;
    // Interrupt status fields.
    localparam int IRQ_W = 4;
    localparam int IRQ_READY = 0;
    localparam int IRQ_SIM_IN = 1;
    localparam int IRQ_SIM_OUT = 2;
    localparam int IRQ_WAKE = 3;
    localparam logic [3:0] IRQ_RESET = 4'h0;
    localparam logic [8:0] OUT_LEVEL_RESET = 9'h000;
    // Network blink timing.
    localparam int CLK_HZ = 32'h0131_2D00;
    localparam int NET_HALF_MS = 32'h0000_01F4;
    localparam int NET_HALF_CYCLES = NET_HALF_MS * (CLK_HZ / 32'h0000_03E8);
    // Audio signals to and from the audio core.
    typedef struct packed {
        logic tx_data;
        logic clk_out;
        logic clk_oe;
        logic wa_out;
        logic wa_oe;
    } mpc_aud_tx_s;
    typedef struct packed {
        logic rx_data;
        logic clk_in;
        logic wa_in;
    } mpc_aud_rx_s;
    // Function held by a pin after reset.
    function automatic mpc_func_e default_func(input int pin);
        mpc_func_e f;
        f = FN_AUDIO;
        if (pin == GENERAL_PIN_ONE) f = FN_DISABLED;
        else if (pin == GENERAL_PIN_TWO) f = FN_RX_SUPPLY;
        else if (pin == GENERAL_PIN_THREE) f = FN_RX_READY;
        else if (pin == GENERAL_PIN_FOUR) f = FN_OUTPUT;
        else if (pin == GENERAL_PIN_FIVE) f = FN_SIM_DETECT;
        return f;
    endfunction
    // Whether a function code may be placed on a given pin.
    function automatic logic func_allowed(input int pin, input logic [3:0] code);
        logic ok;
        ok = 1'b0;
        case (code)
            FN_DISABLED, FN_INPUT, FN_OUTPUT: ok = 1'b1;
            FN_NET_STATUS, FN_RX_SUPPLY: ok = (pin <= GENERAL_PIN_FOUR);
            FN_RX_READY: ok = (pin == GENERAL_PIN_THREE);
            FN_RTC_SHARE: ok = (pin == GENERAL_PIN_FOUR);
            FN_SIM_DETECT, FN_SIM_HOT: ok = (pin == GENERAL_PIN_FIVE);
            FN_AUDIO: ok = (pin >= AUDIO_TXD_PIN);
            default: ok = 1'b0;
        endcase
        return ok;
    endfunction
endpackage

// ===== design/mpc_sync.sv
// Two flip-flop synchroniser for a vector of pin levels.
// Assumes the inputs are asynchronous and the reset is synchronous to clk_i.
module mpc_sync #(
    parameter int W = 9
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] sync;
    } mpc_sync_s;

    mpc_sync_s s;
    mpc_sync_s next_s;

    // The first stage feeds only the second stage.
    always_comb begin
        next_s.meta = d_i;
        next_s.sync = s.meta;
    end

    // Both stages clear on reset.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign q_o = s.sync;
endmodule

// ===== tb/mpc_far_side.sv
// Far-side model: positioning receiver, SIM socket and the board wiring of the nine pins.
// Assumes the pin ports of the pin configuration block and free levels set by the bench.
module mpc_far_side (
    input wire logic [8:0] drv_i,
    input wire logic [8:0] oe_i,
    input wire logic [8:0] pd_i,
    input wire logic ready_i,
    input wire logic present_i,
    input wire logic [8:0] lvl_i,
    output logic [8:0] wire_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Resolves each wire: block drive first, then the far-side drivers, then the pull-down.
    always_comb begin
        wire_o = lvl_i;
        wire_o[2] = ready_i;
        wire_o[4] = present_i;
        for (int i = 0; i < 9; i++) begin
            if (oe_i[i]) begin
                wire_o[i] = drv_i[i];
            end else if (pd_i[i] && i != 2 && i != 4) begin
                wire_o[i] = 1'b0;
            end
        end
    end
endmodule

// ===== tb/multifunction_pin_config_test.sv
// Self-checking bench for the multifunction pin configuration block.
// Assumes the block's package is compiled first and the far-side model beside it.
module multifunction_pin_config_test;
    timeunit 1ns;
    timeprecision 1ps;
    `define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin num_errors++; \
        $display("MISMATCH %s expected %0h seen %0h", n, e, s); end end
    // Address and expected read value after reset, one row per address, the last one unmapped.
    localparam logic [39:0] ROWS [12] = '{40'h0000000000, 40'h0400000004, 40'h0800000005, 40'h0C00000002,
        40'h1000000007, 40'h1400000009, 40'h2000000009, 40'h2400000000, 40'h3000000000, 40'h3400000000,
        40'h3C00000002, 40'h4000000000};
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, mclk, r13 = 1'b0, r26 = 1'b0, act = 1'b0, rtc = 1'b0;
    logic idle = 1'b0, sim_en, wake, irq, ready = 1'b0, present = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat = 32'h0, rdat, rd;
    logic [8:0] pout, oe, pd, wires, lvl = 9'h000;
    mpc_pkg::mpc_aud_tx_s aud_tx = 5'h00;
    mpc_pkg::mpc_aud_rx_s aud_rx;
    int num_errors = 0;
    int tests_run = 0;
    int ones;
    always #25 clk_i = ~clk_i;
    always #38.462 r13 = ~r13;
    always #19.231 r26 = ~r26;
    mpc_top #(.NET_HALF_CYCLES(16)) mpc_top_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .pin_i(wires), .pin_o(pout), .pin_oe_o(oe), .pin_pd_o(pd), .mclk_ref13_i(r13), .mclk_ref26_i(r26),
        .master_clock_out_pin_o(mclk), .aud_tx_i(aud_tx), .aud_rx_o(aud_rx), .aud_active_i(act),
        .rtc_sync_i(rtc), .idle_i(idle), .sim_enable_o(sim_en), .wake_o(wake), .irq_o(irq));
    mpc_far_side mpc_far_side_inst (.drv_i(pout), .oe_i(oe), .pd_i(pd), .ready_i(ready), .present_i(present),
        .lvl_i(lvl), .wire_o(wires));
    // One classic Wishbone cycle: hold the request until ack is seen, then one idle cycle.
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        we <= w;
        adr <= a;
        dat <= d;
        {cyc, stb} <= 2'b11;
        do begin
            @(posedge clk_i);
        end while (ack !== 1'b1);
        rd = rdat;
        {cyc, stb} <= 2'b00;
        @(posedge clk_i);
    endtask
    // Register write and checked register read.
    task automatic w(input logic [7:0] a, input logic [31:0] d);
        wb(1'b1, a, d);
    endtask
    task automatic r(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        `CHK("register", e, rd)
    endtask
    // Prints the counts and the verdict, then ends the run.
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Cuts a hang short well beyond the expected run length.
    initial begin
        repeat (4000) @(posedge clk_i);
        num_errors++;
        test_done();
    end
    // Main sequence: reset pin checks and reset table first, then the hand-written cases.
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        `CHK("pull-downs", 9'h001, pd)
        `CHK("pin four", 2'b10, {oe[3], pout[3]})
        foreach (ROWS[i]) r(ROWS[i][39:32], ROWS[i][31:0]);
        w(8'h30, 32'h1);
        `CHK("supply", 2'b11, {oe[1], pout[1]})
        w(8'h24, 32'h8);
        `CHK("output", 1'b1, pout[3])
        w(8'h10, 32'h9);
        r(8'h10, 32'h7);
        w(8'h08, 32'h6);
        r(8'h08, 32'h5);
        w(8'h00, 32'h3);
        w(8'h2C, 32'h3);
        `CHK("net data", 3'b101, {oe[0], pd[0], pout[0]})
        w(8'h2C, 32'h0);
        `CHK("net none", 1'b0, pout[0])
        w(8'h2C, 32'h2);
        ones = 0;
        repeat (8) begin
            @(posedge clk_i);
            ones += pout[0];
        end
        `CHK("net roam", 4, ones)
        w(8'h2C, 32'h1);
        ones = 0;
        repeat (32) begin
            @(posedge clk_i);
            ones += pout[0];
        end
        `CHK("net home", 16, ones)
        w(8'h00, 32'h4);
        `CHK("supply moved", 2'b11, {oe[0], pout[0]})
        w(8'h04, 32'h1);
        lvl <= 9'h002;
        repeat (4) @(posedge clk_i);
        r(8'h28, 32'h2);
        `CHK("input oe", 1'b0, oe[1])
        w(8'h38, 32'h1);
        w(8'h30, 32'h10);
        ready <= 1'b1;
        idle <= 1'b1;
        repeat (4) @(posedge clk_i);
        `CHK("irq ready", 1'b1, irq)
        `CHK("wake", 1'b1, wake)
        w(8'h38, 32'h0);
        `CHK("irq masked", 1'b0, irq)
        w(8'h38, 32'h1);
        w(8'h34, 32'h1);
        `CHK("irq cleared", 1'b0, irq)
        w(8'h0C, 32'h6);
        rtc <= 1'b1;
        repeat (2) @(posedge clk_i);
        `CHK("rtc", 2'b11, {oe[3], pout[3]})
        w(8'h10, 32'h8);
        for (int k = 0; k < 3; k++) begin
            present <= (k != 1);
            repeat (4) @(posedge clk_i);
            `CHK("sim enable", k != 1, sim_en)
        end
        aud_tx <= 5'h10;
        repeat (2) @(posedge clk_i);
        `CHK("audio tx", 1'b1, pout[5])
        lvl <= 9'h042;
        repeat (4) @(posedge clk_i);
        `CHK("audio rx", 1'b1, aud_rx.rx_data)
        w(8'h18, 32'h2);
        `CHK("audio released", 1'b0, aud_rx.rx_data)
        w(8'h30, 32'hA);
        @(posedge r13);
        #1;
        `CHK("clock 13", 1'b1, mclk)
        @(posedge clk_i);
        w(8'h30, 32'hE);
        @(posedge r26);
        #1;
        `CHK("clock 26", 1'b1, mclk)
        @(posedge clk_i);
        w(8'h30, 32'h6);
        @(posedge r26);
        #1;
        `CHK("clock gated", 1'b0, mclk)
        @(posedge clk_i);
        act <= 1'b1;
        repeat (2) @(posedge clk_i);
        @(posedge r26);
        #1;
        `CHK("clock audio", 1'b1, mclk)
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        `CHK("reset again", {9'h001, 9'h02A, 3'b100}, {pd, oe, sim_en, wake, mclk})
        test_done();
    end
endmodule
